//--- bench/bps_ext_pins.sv
// Purpose: far side of the shared pins, other devices and pull-ups
// Assumes: bench decides when an outside device drives a line
// Notes: an undriven line without pull-up toggles every cycle
`timescale 1ns/1ns
`default_nettype none
module bps_ext_pins
(
  // Clock
  input wire logic core_clk,
  // Device pin drive, bit 0 port5_bit0, bits 1..3 port4_bit5..7
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  input wire logic [3:0] pinPull,
  // Outside drivers
  input wire logic [3:0] extEn,
  input wire logic [3:0] extVal,
  // Resolved line levels
  output logic [3:0] pinLevel
);
  logic [3:0] lastLvl_q = 4'h0;

  // Floating lines never settle, so a missed pull-up shows
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pinLevel[i] = pinOe[i] ? pinOut[i] : extEn[i] ? extVal[i] :
        pinPull[i] ? 1'b1 : ~lastLvl_q[i];
  end

  always_ff @(posedge core_clk)
    lastLvl_q <= pinLevel;
endmodule // bps_ext_pins
`default_nettype wire

//--- bench/test_bus_control_pin_function_select.sv
// Purpose: register driven checks of the shared pin selection
// Assumes: register byte address is four times its index
// Notes: pins are sampled at clock edges, one edge after settle
`timescale 1ns/1ns
`default_nettype none
module test_bus_control_pin_function_select;
  import bps_pkg::*;
  localparam logic [11:0] A_MODE = 12'h010;
  localparam logic [11:0] A_CS = 12'h020;
  localparam logic [11:0] A_P4D = 12'hFA0;
  localparam logic [11:0] A_P5D = 12'hFA4;
  localparam logic [11:0] A_P4DIR = 12'hFA8;
  localparam logic [11:0] A_P5DIR = 12'hFAC;
  localparam logic [11:0] A_LVL = 12'hFC0;
  localparam logic [11:0] A_PULL = 12'hFF4;
  logic core_clk = 1'b0;
  logic sys_rst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb, extEn, extVal;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, storeStrobeN, lowByteStoreStrobeN;
  logic [3:1] areaN;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [3:0] pOut, pOe, pPull, pinLevel;
  int errors, numChecks, cycles;
  logic [11:0] regA [5] = '{A_MODE, A_CS, A_P4DIR, A_P5DIR, A_PULL};

  bps_pin_select dut_u (
    .core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .storeStrobeN, .lowByteStoreStrobeN,
    .area1SelectLineN(areaN[1]), .area2SelectLineN(areaN[2]),
    .area3SelectLineN(areaN[3]), .port5Bit0In(pinLevel[0]),
    .port5Bit0Out(pOut[0]), .port5Bit0Oe(pOe[0]),
    .port5Bit0PullUp(pPull[0]), .port4Bit5In(pinLevel[1]),
    .port4Bit5Out(pOut[1]), .port4Bit5Oe(pOe[1]),
    .port4Bit5PullUp(pPull[1]), .port4Bit6In(pinLevel[2]),
    .port4Bit6Out(pOut[2]), .port4Bit6Oe(pOe[2]),
    .port4Bit6PullUp(pPull[2]), .port4Bit7In(pinLevel[3]),
    .port4Bit7Out(pOut[3]), .port4Bit7Oe(pOe[3]),
    .port4Bit7PullUp(pPull[3])
  );

  bps_ext_pins ext_u (
    .core_clk, .pinOut(pOut), .pinOe(pOe), .pinPull(pPull), .extEn,
    .extVal, .pinLevel
  );

  always #20 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Bits compared: {out, oe, pull} under mask
  task automatic pin(input int p, input logic [2:0] e, input logic [2:0] m);
    chk({29'h0, {pOut[p], pOe[p], pPull[p]} & m}, {29'h0, e & m});
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e,
    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, {24'h00_0000, e});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      give_verdict();
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    s_axi_wstrb = 4'h1;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    {storeStrobeN, lowByteStoreStrobeN, areaN} = 5'h1F;
    extEn = 4'hE;
    extVal = 4'hA;
    tick(2);
    sys_rst <= 1'b0;
    tick(1);
    for (int p = 0; p < 4; p++) pin(p, 3'b100, 3'b111);
    foreach (regA[k]) rd(regA[k], 8'h00, RESP_OKAY);
    wr(12'h100, 8'hFF, RESP_SLVERR);
    rd(12'h100, 8'h00, RESP_SLVERR);
    wr(A_PULL, 8'h04, RESP_OKAY);
    pin(0, 3'b000, 3'b011);
    tick(1);
    pin(0, 3'b001, 3'b011);
    for (int p = 1; p < 4; p++) pin(p, 3'b000, 3'b011);
    rd(A_LVL, 8'hA1, RESP_OKAY);
    wr(A_LVL, 8'h00, RESP_OKAY);
    rd(A_PULL, 8'h04, RESP_OKAY);
    wr(A_PULL, 8'h02, RESP_OKAY);
    tick(1);
    pin(0, 3'b000, 3'b011);
    for (int p = 1; p < 4; p++) pin(p, 3'b001, 3'b011);
    extEn <= 4'h0;
    wr(A_PULL, 8'h06, RESP_OKAY);
    wr(A_P5DIR, 8'h01, RESP_OKAY);
    wr(A_P4DIR, 8'hE0, RESP_OKAY);
    for (int v = 1; v >= 0; v--)
    begin
      wr(A_P5D, v[0] ? 8'hFF : 8'h00, RESP_OKAY);
      wr(A_P4D, v[0] ? 8'hFF : 8'h00, RESP_OKAY);
      tick(1);
      for (int p = 0; p < 4; p++) pin(p, {v[0], 2'b10}, 3'b111);
    end
    wr(A_P4DIR, 8'h00, RESP_OKAY);
    // Bus mode but no select enables: upper port 4 stays a port
    for (int s = 0; s < 2; s++)
    begin
      wr(A_MODE, s[0] ? 8'h05 : 8'h01, RESP_OKAY);
      tick(1);
      for (int p = 1; p < 4; p++) pin(p, 3'b001, 3'b011);
      for (int v = 0; v < 2; v++)
      begin
        storeStrobeN <= v[0] ^ s[0];
        lowByteStoreStrobeN <= v[0] ^ ~s[0];
        tick(2);
        pin(0, {v[0], 2'b10}, 3'b111);
      end
    end
    for (int i = 1; i < 4; i++)
    begin
      wr(A_CS, 8'(8'h01 << i), RESP_OKAY);
      for (int v = 0; v < 2; v++)
      begin
        areaN <= v[0] ? 3'h7 : 3'h0;
        tick(2);
        pin(i, {v[0], 2'b10}, 3'b111);
        for (int j = 1; j < 4; j++)
          if (j != i) pin(j, 3'b001, 3'b011);
      end
    end
    // Direction ignored in bus mode; mode bit 1 alone means port mode
    wr(A_P5DIR, 8'h00, RESP_OKAY);
    tick(1);
    pin(0, 3'b010, 3'b011);
    wr(A_MODE, 8'h02, RESP_OKAY);
    pin(0, 3'b010, 3'b011);
    tick(1);
    pin(0, 3'b001, 3'b011);
    pin(3, 3'b001, 3'b011);
    rd(A_MODE, 8'h02, RESP_OKAY);
    give_verdict();
  end
endmodule // test_bus_control_pin_function_select
`default_nettype wire

//--- logic/bps_axi_slave.sv
// Purpose: AXI4-Lite slave front end for the pin select registers
// Assumes: one write and one read outstanding at most
// Notes: write strobe pulses one cycle once address and data are held
`timescale 1ns/1ns
`default_nettype none
module bps_axi_slave
  import bps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Write channels
  input wire logic [bps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [bps_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register file side
  output logic wrEn,
  output logic [bps_pkg::ADDR_W-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  output logic [bps_pkg::ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData
);
  logic rdPend_q;
  assign wrEn = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wrAddr <= '0;
      wrData <= '0;
      wrStrb <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        wrAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrEn)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= bps_is_mapped(wrAddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      rdAddr <= '0;
      rdPend_q <= 1'b0;
    end
    else
    begin
      rdPend_q <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        rdAddr <= s_axi_araddr;
        s_axi_arready <= 1'b0;
        rdPend_q <= 1'b1;
      end
      if (rdPend_q)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdData;
        s_axi_rresp <= bps_is_mapped(rdAddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // bps_axi_slave
`default_nettype wire

//--- logic/bps_pin_cell.sv
// Purpose: one shared pin, alternate function or general port bit
// Assumes: control inputs come from the core_clk domain
// Notes: all pin controls registered so pins never glitch
`timescale 1ns/1ns
`default_nettype none
module bps_pin_cell
  import bps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Selection
  input wire logic altSel,
  input wire logic altVal,
  input wire logic dirOut,
  input wire logic pullSel,
  input wire logic portVal,
  // Pin side
  output logic pinOut,
  output logic pinOe,
  output logic pinPull
);
  wire logic outD = altSel ? altVal : portVal;
  wire logic oeD = altSel | dirOut;
  // Pull-up only while the pin is a port input
  wire logic pullD = ~altSel & ~dirOut & pullSel;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pinOut <= PIN_OUT_RESET;
      pinOe <= 1'b0;
      pinPull <= 1'b0;
    end
    else
    begin
      pinOut <= outD;
      pinOe <= oeD;
      pinPull <= pullD;
    end
  end
endmodule // bps_pin_cell
`default_nettype wire

//--- logic/bps_pin_select.sv
// Purpose: function select for the write strobe and chip select pins
// Assumes: strobes and selects arrive active low from the bus unit
// Notes: pin outputs lag control registers by one clock
//
// Notes on behaviour
// - In bus mode with the strobe select bit clear, port5_bit0 drives the combined store strobe.
// - In bus mode with the strobe select bit set, port5_bit0 drives the low-byte store strobe.
// - In port mode with direction and pull-up clear, port5_bit0 is a floating input.
// - In port mode with direction clear and pull-up set, port5_bit0 is a pulled-up input.
// - In port mode with direction set, port5_bit0 drives its port value and the pull-up is off.
// - In bus mode with the area-3 enable set, port4_bit7 drives the area-3 select line.
// - In bus mode with the area-2 enable set, port4_bit6 drives the area-2 select line.
// - In bus mode with the area-1 enable set, port4_bit5 drives the area-1 select line.
// - Port4 bits 5 to 7 without their select function and with direction clear are inputs.
// - Those inputs take the shared port 4 upper pull-up bit as their pull-up enable.
// - Those bits with direction set drive their port values whatever the pull-up bit.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module bps_pin_select
  import bps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // AXI4-Lite write
  input wire logic [bps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [bps_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Bus unit strobes, active low
  input wire logic storeStrobeN,
  input wire logic lowByteStoreStrobeN,
  input wire logic area1SelectLineN,
  input wire logic area2SelectLineN,
  input wire logic area3SelectLineN,
  // Pin port5_bit0
  input wire logic port5Bit0In,
  output logic port5Bit0Out,
  output logic port5Bit0Oe,
  output logic port5Bit0PullUp,
  // Pin port4_bit5
  input wire logic port4Bit5In,
  output logic port4Bit5Out,
  output logic port4Bit5Oe,
  output logic port4Bit5PullUp,
  // Pin port4_bit6
  input wire logic port4Bit6In,
  output logic port4Bit6Out,
  output logic port4Bit6Oe,
  output logic port4Bit6PullUp,
  // Pin port4_bit7
  input wire logic port4Bit7In,
  output logic port4Bit7Out,
  output logic port4Bit7Oe,
  output logic port4Bit7PullUp
);
  import bps_pkg::*;

  logic [7:0] procMode_q;
  logic [7:0] csCtrl_q;
  logic [7:0] p4Dir_q;
  logic [7:0] p5Dir_q;
  logic [7:0] pullUp_q;
  logic [7:0] p4Data_q;
  logic [7:0] p5Data_q;
  logic [3:0] pinMeta_q;
  logic [3:0] pinLevel_q;
  logic wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;

  bps_axi_slave u_slave (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  // Write decode; only byte lane 0 carries register data
  wire logic wrLane = wrEn & wrStrb[0];
  wire logic wrMode = wrLane & (wrAddr == bps_reg_addr(PROC_MODE_IDX));
  wire logic wrCs = wrLane & (wrAddr == bps_reg_addr(CS_CTRL_IDX));
  wire logic wrP4Dir = wrLane & (wrAddr == bps_reg_addr(P4_DIR_IDX));
  wire logic wrP5Dir = wrLane & (wrAddr == bps_reg_addr(P5_DIR_IDX));
  wire logic wrPull = wrLane & (wrAddr == bps_reg_addr(PULLUP_IDX));
  wire logic wrP4Dat = wrLane & (wrAddr == bps_reg_addr(P4_DATA_IDX));
  wire logic wrP5Dat = wrLane & (wrAddr == bps_reg_addr(P5_DATA_IDX));

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      procMode_q <= REG_RESET;
      csCtrl_q <= REG_RESET;
      p4Dir_q <= REG_RESET;
      p5Dir_q <= REG_RESET;
      pullUp_q <= REG_RESET;
      p4Data_q <= REG_RESET;
      p5Data_q <= REG_RESET;
    end
    else
    begin
      if (wrMode)
        procMode_q <= wrData[7:0];
      if (wrCs)
        csCtrl_q <= wrData[7:0];
      if (wrP4Dir)
        p4Dir_q <= wrData[7:0];
      if (wrP5Dir)
        p5Dir_q <= wrData[7:0];
      if (wrPull)
        pullUp_q <= wrData[7:0];
      if (wrP4Dat)
        p4Data_q <= wrData[7:0];
      if (wrP5Dat)
        p5Data_q <= wrData[7:0];
    end
  end

  // Pins are asynchronous to core_clk: two stages before use
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pinMeta_q <= PIN_SYNC_RESET;
      pinLevel_q <= PIN_SYNC_RESET;
    end
    else
    begin
      pinMeta_q <= {port4Bit7In, port4Bit6In, port4Bit5In, port5Bit0In};
      pinLevel_q <= pinMeta_q;
    end
  end

  // Read mux
  wire logic [7:0] pinLevelByte = {pinLevel_q[3:1], 4'h0, pinLevel_q[0]};
  assign rdData =
    (rdAddr == bps_reg_addr(PROC_MODE_IDX)) ? {24'h00_0000, procMode_q} :
    (rdAddr == bps_reg_addr(CS_CTRL_IDX)) ? {24'h00_0000, csCtrl_q} :
    (rdAddr == bps_reg_addr(P4_DIR_IDX)) ? {24'h00_0000, p4Dir_q} :
    (rdAddr == bps_reg_addr(P5_DIR_IDX)) ? {24'h00_0000, p5Dir_q} :
    (rdAddr == bps_reg_addr(PULLUP_IDX)) ? {24'h00_0000, pullUp_q} :
    (rdAddr == bps_reg_addr(P4_DATA_IDX)) ? {24'h00_0000, p4Data_q} :
    (rdAddr == bps_reg_addr(P5_DATA_IDX)) ? {24'h00_0000, p5Data_q} :
    (rdAddr == bps_reg_addr(PIN_LEVEL_IDX)) ?
      {24'h00_0000, pinLevelByte} : 32'h0000_0000;

  // Mode bit 0 alone selects the bus functions; bit 1 does not matter
  wire logic busMode = procMode_q[MODE_BIT0];
  wire logic strobeSel = busMode;
  wire logic strobeVal = procMode_q[RW_SEL] ?
    lowByteStoreStrobeN : storeStrobeN;
  wire logic area1Sel = busMode & csCtrl_q[AREA1_EN];
  wire logic area2Sel = busMode & csCtrl_q[AREA2_EN];
  wire logic area3Sel = busMode & csCtrl_q[AREA3_EN];

  bps_pin_cell u_port5b0 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .altSel(strobeSel),
    .altVal(strobeVal),
    .dirOut(p5Dir_q[PORT5_BIT0_POS]),
    .pullSel(pullUp_q[PULL_PORT5_LOW]),
    .portVal(p5Data_q[PORT5_BIT0_POS]),
    .pinOut(port5Bit0Out),
    .pinOe(port5Bit0Oe),
    .pinPull(port5Bit0PullUp)
  );

  bps_pin_cell u_port4b5 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .altSel(area1Sel),
    .altVal(area1SelectLineN),
    .dirOut(p4Dir_q[PORT4_BIT5_POS]),
    .pullSel(pullUp_q[PULL_P44_47]),
    .portVal(p4Data_q[PORT4_BIT5_POS]),
    .pinOut(port4Bit5Out),
    .pinOe(port4Bit5Oe),
    .pinPull(port4Bit5PullUp)
  );

  bps_pin_cell u_port4b6 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .altSel(area2Sel),
    .altVal(area2SelectLineN),
    .dirOut(p4Dir_q[PORT4_BIT6_POS]),
    .pullSel(pullUp_q[PULL_P44_47]),
    .portVal(p4Data_q[PORT4_BIT6_POS]),
    .pinOut(port4Bit6Out),
    .pinOe(port4Bit6Oe),
    .pinPull(port4Bit6PullUp)
  );

  bps_pin_cell u_port4b7 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .altSel(area3Sel),
    .altVal(area3SelectLineN),
    .dirOut(p4Dir_q[PORT4_BIT7_POS]),
    .pullSel(pullUp_q[PULL_P44_47]),
    .portVal(p4Data_q[PORT4_BIT7_POS]),
    .pinOut(port4Bit7Out),
    .pinOe(port4Bit7Oe),
    .pinPull(port4Bit7PullUp)
  );

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  AST_PORT5_STORE_STROBE: assert property (
    (busMode && !procMode_q[RW_SEL]) |=> (port5Bit0Oe &&
      !port5Bit0PullUp && port5Bit0Out == $past(storeStrobeN)))
    else $error("combined store strobe not on port5_bit0");

  AST_PORT5_LOW_STROBE: assert property (
    (busMode && procMode_q[RW_SEL]) |=> (port5Bit0Oe &&
      port5Bit0Out == $past(lowByteStoreStrobeN)))
    else $error("low-byte store strobe not on port5_bit0");

  AST_PORT5_FLOAT_IN: assert property (
    (!busMode && !p5Dir_q[PORT5_BIT0_POS] && !pullUp_q[PULL_PORT5_LOW])
      |=> (!port5Bit0Oe && !port5Bit0PullUp))
    else $error("port5_bit0 not a floating input");

  AST_PORT5_PULLED_IN: assert property (
    (!busMode && !p5Dir_q[PORT5_BIT0_POS] && pullUp_q[PULL_PORT5_LOW])
      |=> (!port5Bit0Oe && port5Bit0PullUp))
    else $error("port5_bit0 pull-up not enabled");

  AST_PORT5_PORT_OUT: assert property (
    (!busMode && p5Dir_q[PORT5_BIT0_POS]) |=> (port5Bit0Oe &&
      !port5Bit0PullUp &&
      port5Bit0Out == $past(p5Data_q[PORT5_BIT0_POS])))
    else $error("port5_bit0 not driving port value");

  AST_PORT4_BIT7_AREA3: assert property (
    area3Sel |=> (port4Bit7Oe && !port4Bit7PullUp &&
      port4Bit7Out == $past(area3SelectLineN)))
    else $error("area-3 select not on port4_bit7");

  AST_PORT4_BIT6_AREA2: assert property (
    area2Sel |=> (port4Bit6Oe && port4Bit6Out == $past(area2SelectLineN)))
    else $error("area-2 select not on port4_bit6");

  AST_PORT4_BIT5_AREA1: assert property (
    area1Sel |=> (port4Bit5Oe && port4Bit5Out == $past(area1SelectLineN)))
    else $error("area-1 select not on port4_bit5");

  AST_PORT4_BIT5_PORT_IN: assert property (
    (!area1Sel && !p4Dir_q[PORT4_BIT5_POS]) |=> !port4Bit5Oe)
    else $error("port4_bit5 driven while a port input");

  AST_PORT4_BIT6_PORT_IN: assert property (
    (!area2Sel && !p4Dir_q[PORT4_BIT6_POS]) |=> !port4Bit6Oe)
    else $error("port4_bit6 driven while a port input");

  AST_PORT4_BIT7_PORT_IN: assert property (
    (!area3Sel && !p4Dir_q[PORT4_BIT7_POS]) |=> !port4Bit7Oe)
    else $error("port4_bit7 driven while a port input");

  AST_PORT4_BIT5_PULL: assert property (
    (!area1Sel && !p4Dir_q[PORT4_BIT5_POS]) |=>
      (port4Bit5PullUp == $past(pullUp_q[PULL_P44_47])))
    else $error("port4_bit5 pull-up does not follow its bit");

  AST_PORT4_BIT6_PULL: assert property (
    (!area2Sel && !p4Dir_q[PORT4_BIT6_POS]) |=>
      (!port4Bit6Oe && port4Bit6PullUp == $past(pullUp_q[PULL_P44_47])))
    else $error("port4_bit6 pull-up does not follow its bit");

  AST_PORT4_BIT7_PULL: assert property (
    (!area3Sel && !p4Dir_q[PORT4_BIT7_POS]) |=>
      (port4Bit7PullUp == $past(pullUp_q[PULL_P44_47])))
    else $error("port4_bit7 pull-up does not follow its bit");

  AST_PORT4_BIT5_PORT_OUT: assert property (
    (!area1Sel && p4Dir_q[PORT4_BIT5_POS]) |=> (port4Bit5Oe &&
      !port4Bit5PullUp &&
      port4Bit5Out == $past(p4Data_q[PORT4_BIT5_POS])))
    else $error("port4_bit5 not driving port value");

  AST_PORT4_BIT6_PORT_OUT: assert property (
    (!area2Sel && p4Dir_q[PORT4_BIT6_POS]) |=> (port4Bit6Oe &&
      !port4Bit6PullUp &&
      port4Bit6Out == $past(p4Data_q[PORT4_BIT6_POS])))
    else $error("port4_bit6 not driving port value");

  AST_PORT4_BIT7_PORT_OUT: assert property (
    (!area3Sel && p4Dir_q[PORT4_BIT7_POS]) |=> (port4Bit7Oe &&
      !port4Bit7PullUp &&
      port4Bit7Out == $past(p4Data_q[PORT4_BIT7_POS])))
    else $error("port4_bit7 not driving port value");

  sequence modeToBus;
    wrMode && wrData[MODE_BIT0];
  endsequence

  sequence modeToPort;
    wrMode && !wrData[MODE_BIT0] && wrP5Dir == 1'b0 &&
      !p5Dir_q[PORT5_BIT0_POS];
  endsequence

  AST_MODE_WRITE_BUS: assert property (
    modeToBus |-> ##1 busMode ##1 port5Bit0Oe)
    else $error("mode write did not reach port5_bit0 in time");

  AST_MODE_WRITE_PORT: assert property (
    modeToPort |-> ##1 !busMode ##1 !port5Bit0Oe)
    else $error("mode write did not release port5_bit0");
endmodule // bps_pin_select
`default_nettype wire

//--- logic/bps_pkg.sv
// Purpose: shared constants for the bus pin function selector
// Assumes: AXI4-Lite access, one aligned 32-bit word per register
// Notes: byte address of a register is four times its index
package bps_pkg;
  localparam int ADDR_W = 12;
  // Register indices
  localparam logic [11:0] PROC_MODE_IDX = 12'h004;
  localparam logic [11:0] CS_CTRL_IDX = 12'h008;
  localparam logic [11:0] P4_DATA_IDX = 12'h3E8;
  localparam logic [11:0] P5_DATA_IDX = 12'h3E9;
  localparam logic [11:0] P4_DIR_IDX = 12'h3EA;
  localparam logic [11:0] P5_DIR_IDX = 12'h3EB;
  localparam logic [11:0] PIN_LEVEL_IDX = 12'h3F0;
  localparam logic [11:0] PULLUP_IDX = 12'h3FD;
  // Field positions
  localparam int MODE_BIT0 = 0;
  localparam int MODE_BIT1 = 1;
  localparam int RW_SEL = 2;
  localparam int AREA1_EN = 1;
  localparam int AREA2_EN = 2;
  localparam int AREA3_EN = 3;
  localparam int PORT5_BIT0_POS = 0;
  localparam int PORT4_BIT5_POS = 5;
  localparam int PORT4_BIT6_POS = 6;
  localparam int PORT4_BIT7_POS = 7;
  localparam int PULL_P44_47 = 1;
  localparam int PULL_PORT5_LOW = 2;
  // Values after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] PIN_SYNC_RESET = 4'h0;
  localparam logic PIN_OUT_RESET = 1'b1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  function automatic logic [ADDR_W-1:0] bps_reg_addr(
    input logic [11:0] idx);
    return {idx[9:0], 2'b00};
  endfunction

  function automatic logic bps_is_mapped(input logic [ADDR_W-1:0] a);
    return a == bps_reg_addr(PROC_MODE_IDX) ||
      a == bps_reg_addr(CS_CTRL_IDX) ||
      a == bps_reg_addr(P4_DATA_IDX) ||
      a == bps_reg_addr(P5_DATA_IDX) ||
      a == bps_reg_addr(P4_DIR_IDX) ||
      a == bps_reg_addr(P5_DIR_IDX) ||
      a == bps_reg_addr(PIN_LEVEL_IDX) ||
      a == bps_reg_addr(PULLUP_IDX);
  endfunction
endpackage
